/* File: design/reference_channel_control.sv */
// reference channel control: phase, frequency, amplitude and harmonic
// settings with their limits, reference source and trigger, lock tracking
// assumes panel keys and knob pulses arrive from a scanner on this clock;
// the two reference pins are asynchronous and are synchronised here
//
// Function
// - phase setting -180..+180 in 0.01 degree
// - phase shifts only detector sine, not output
// - zeroing subtracts measured phase, aborts if unstable
// - quarter-turn keys add or subtract 90.000
// - both quarter-turn keys together zero phase
// - external mode: show measured frequency, knob inert
// - external too fast for N: harmonic back to 1
// - internal frequency 0.001 Hz..102 kHz, 4.5 digits
// - internal upper limit is 102 kHz over N
// - amplitude 4 mVrms..5 Vrms in 2 mV steps
// - detector runs at harmonic times reference
// - harmonic indicator flashes while N above one
// - harmonic up to 19999 within 102 kHz
// - refused harmonic raise shows overrange message
// - source key toggles external and internal
// - external lock range 0.001 Hz..102 kHz
// - internal mode ignores the reference input
// - edge modes lock to chosen logic edge
// - sine mode locks to rising zero crossings
// - lock-lost indicator whenever lock is missing in external mode
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module reference_channel_control #(
  parameter longint LOCK_TIMEOUT = refchan_pkg::LOCK_TIMEOUT_CYCLES,
  parameter longint BLINK_PERIOD = refchan_pkg::BLINK_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire refchan_pkg::bus_req_type bus,
  output logic [31:0] rdata,
  input wire logic key_plus90,
  input wire logic key_minus90,
  input wire logic key_source,
  input wire logic key_trig,
  input wire logic key_phase_zero,
  input wire logic knob_up,
  input wire logic knob_down,
  input wire refchan_pkg::panel_view_type view,
  input wire logic signed [15:0] meas_phase,
  input wire logic meas_phase_stable,
  input wire logic ref_ttl_pin,
  input wire logic ref_sine_cmp_pin,
  output refchan_pkg::psd_ctrl_type psd_ctrl,
  output logic [11:0] sine_ampl,
  output logic ttl_sync_out,
  output logic harm_led,
  output logic internal_led,
  output logic unlock_led,
  output logic harmonic_overrange_message,
  output logic phase_bad_message
);
  generate
    if (LOCK_TIMEOUT <= longint'(refchan_pkg::MIN_PERIOD) || LOCK_TIMEOUT >= (64'sd1 <<< 38)) begin : g_bad_timeout
      $error("LOCK_TIMEOUT out of range");
    end
    if (BLINK_PERIOD < 2 || BLINK_PERIOD >= (64'sd1 <<< 32)) begin : g_bad_blink
      $error("BLINK_PERIOD out of range");
    end
  endgenerate

  localparam logic [37:0] TIMEOUT = 38'(LOCK_TIMEOUT);
  localparam logic [31:0] BLINK = 32'(BLINK_PERIOD - 1);

  typedef enum {LK_UNLOCKED, LK_ACQUIRE, LK_LOCKED} lock_state_type;

  function automatic logic signed [15:0] wrap_phase(input logic signed [16:0] p);
    logic signed [16:0] r;
    r = p;
    if (p > refchan_pkg::PHASE_LIMIT) r = p - refchan_pkg::PHASE_FULL;
    else if (p < -refchan_pkg::PHASE_LIMIT) r = p + refchan_pkg::PHASE_FULL;
    return r[15:0];
  endfunction : wrap_phase

  function automatic logic int_fits(input logic [29:0] f, input logic [14:0] n);
    return (46'(f) * 46'(n)) <= 46'(refchan_pkg::FREQ_MAX);
  endfunction : int_fits

  // N times the measured rate (clock over period) above the limit, with no divider
  function automatic logic ext_too_fast(input logic [37:0] p, input logic [14:0] n);
    logic [71:0] lhs;
    logic [71:0] rhs;
    lhs = 72'(n) * 72'(refchan_pkg::CLK_HZ);
    rhs = 72'(p) * 72'(refchan_pkg::FMAX_HZ);
    return lhs > rhs;
  endfunction : ext_too_fast

  // knob step keeps four and a half digits, never finer than 0.1 mHz
  function automatic logic [29:0] freq_step(input logic [29:0] f);
    if (f < 30'd20000) return 30'd1;
    else if (f < 30'd200000) return 30'd10;
    else if (f < 30'd2000000) return 30'd100;
    else if (f < 30'd20000000) return 30'd1000;
    else if (f < 30'd200000000) return 30'd10000;
    else return 30'd100000;
  endfunction : freq_step

  logic internal_reg;
  refchan_pkg::trig_mode_type trig_reg;
  logic signed [15:0] phase_reg;
  logic [29:0] freq_reg;
  logic [11:0] ampl_reg;
  logic [14:0] harm_reg;
  logic overrange_reg;
  logic phase_bad_reg;
  lock_state_type lock_reg;
  logic [37:0] count_reg;
  logic [37:0] period_reg;
  logic [41:0] nco_reg;
  logic [31:0] blink_cnt_reg;
  logic blink_reg;
  logic ttl_s1_reg, ttl_s2_reg, cmp_s1_reg, cmp_s2_reg, sel_prev_reg;

  logic wr_ctrl, wr_phase, wr_freq, wr_ampl, wr_harm, wr_status;
  assign wr_ctrl = bus.wr && bus.addr == refchan_pkg::OFS_CTRL;
  assign wr_phase = bus.wr && bus.addr == refchan_pkg::OFS_PHASE;
  assign wr_freq = bus.wr && bus.addr == refchan_pkg::OFS_FREQ;
  assign wr_ampl = bus.wr && bus.addr == refchan_pkg::OFS_AMPL;
  assign wr_harm = bus.wr && bus.addr == refchan_pkg::OFS_HARM;
  assign wr_status = bus.wr && bus.addr == refchan_pkg::OFS_STATUS;

  logic kn_phase, kn_freq, kn_ampl, kn_harm;
  assign kn_phase = view == refchan_pkg::VIEW_PHASE;
  assign kn_freq = view == refchan_pkg::VIEW_FREQ;
  assign kn_ampl = view == refchan_pkg::VIEW_AMPL;
  assign kn_harm = view == refchan_pkg::VIEW_HARM;

  // reference pins: two flops each before any other logic
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ttl_s1_reg <= 1'b0;
      ttl_s2_reg <= 1'b0;
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
    end else begin
      ttl_s1_reg <= ref_ttl_pin;
      ttl_s2_reg <= ttl_s1_reg;
      cmp_s1_reg <= ref_sine_cmp_pin;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  logic sel_now, ref_edge;
  assign sel_now = (trig_reg == refchan_pkg::TRIG_SINE) ? cmp_s2_reg : ttl_s2_reg;
  // a trigger mode change may fake one edge; the lock logic recovers on the next
  always_comb begin
    case (trig_reg)
      refchan_pkg::TRIG_FALLING: ref_edge = !sel_now && sel_prev_reg;
      default: ref_edge = sel_now && !sel_prev_reg;
    endcase
    if (internal_reg) ref_edge = 1'b0;
  end

  logic [37:0] count_inc;
  assign count_inc = count_reg + 38'd1;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sel_prev_reg <= 1'b0;
      count_reg <= '0;
      period_reg <= '0;
    end else begin
      sel_prev_reg <= sel_now;
      if (ref_edge) begin
        period_reg <= count_inc;
        count_reg <= '0;
      end else if (count_reg < TIMEOUT) begin
        count_reg <= count_inc;
      end
    end
  end

  // lock: a period between the 102 kHz and 0.001 Hz bounds between two edges
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lock_reg <= LK_UNLOCKED;
    end else if (internal_reg) begin
      lock_reg <= LK_UNLOCKED;
    end else begin
      case (lock_reg)
        LK_UNLOCKED: if (ref_edge) lock_reg <= LK_ACQUIRE;
        LK_ACQUIRE, LK_LOCKED: begin
          if (count_reg >= TIMEOUT) lock_reg <= LK_UNLOCKED;
          else if (ref_edge) lock_reg <= (count_inc >= refchan_pkg::MIN_PERIOD) ? LK_LOCKED : LK_ACQUIRE;
        end
        default: lock_reg <= LK_UNLOCKED;
      endcase
    end
  end

  logic locked;
  assign locked = lock_reg == LK_LOCKED;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      internal_reg <= 1'b0;
      trig_reg <= refchan_pkg::TRIG_RISING;
    end else if (wr_ctrl) begin
      internal_reg <= bus.wdata[refchan_pkg::CTRL_INTERNAL_BIT];
      trig_reg <= refchan_pkg::trig_mode_type'(bus.wdata[refchan_pkg::CTRL_TRIG_LSB +: 2] == 2'd3 ?
        2'd0 : bus.wdata[refchan_pkg::CTRL_TRIG_LSB +: 2]);
    end else begin
      if (key_source) internal_reg <= !internal_reg;
      if (key_trig) begin
        case (trig_reg)
          refchan_pkg::TRIG_RISING: trig_reg <= refchan_pkg::TRIG_FALLING;
          refchan_pkg::TRIG_FALLING: trig_reg <= refchan_pkg::TRIG_SINE;
          default: trig_reg <= refchan_pkg::TRIG_RISING;
        endcase
      end
    end
  end

  logic zero_cmd;
  assign zero_cmd = key_phase_zero && !(key_plus90 || key_minus90);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= refchan_pkg::PHASE_RST;
    end else if (key_plus90 && key_minus90) begin
      phase_reg <= '0;
    end else if (key_plus90) begin
      phase_reg <= wrap_phase(17'(phase_reg) + refchan_pkg::PHASE_QUARTER);
    end else if (key_minus90) begin
      phase_reg <= wrap_phase(17'(phase_reg) - refchan_pkg::PHASE_QUARTER);
    end else if (zero_cmd) begin
      if (meas_phase_stable) phase_reg <= wrap_phase(17'(phase_reg) - 17'(meas_phase));
    end else if (kn_phase && knob_up && !knob_down) begin
      if (17'(phase_reg) < refchan_pkg::PHASE_LIMIT) phase_reg <= phase_reg + 16'sd1;
    end else if (kn_phase && knob_down && !knob_up) begin
      if (17'(phase_reg) > -refchan_pkg::PHASE_LIMIT) phase_reg <= phase_reg - 16'sd1;
    end else if (wr_phase) begin
      phase_reg <= wrap_phase(17'(signed'(bus.wdata[15:0])));
    end
  end

  // an aborted zeroing stays flagged until cleared by writing one
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) phase_bad_reg <= 1'b0;
    else if (zero_cmd && !meas_phase_stable) phase_bad_reg <= 1'b1;
    else if (wr_status && bus.wdata[refchan_pkg::ST_PHASE_BAD_BIT]) phase_bad_reg <= 1'b0;
  end

  logic [29:0] fstep, f_up, f_down, f_wr;
  assign fstep = freq_step(freq_reg);
  assign f_up = (freq_reg + fstep > refchan_pkg::FREQ_MAX) ? refchan_pkg::FREQ_MAX : freq_reg + fstep;
  assign f_down = (freq_reg < refchan_pkg::FREQ_MIN + freq_step(freq_reg - 30'd1)) ?
    refchan_pkg::FREQ_MIN : freq_reg - freq_step(freq_reg - 30'd1);
  assign f_wr = bus.wdata[29:0];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      freq_reg <= refchan_pkg::FREQ_RST;
    end else if (internal_reg && kn_freq && knob_up && !knob_down) begin
      if (int_fits(f_up, harm_reg)) freq_reg <= f_up;
    end else if (internal_reg && kn_freq && knob_down && !knob_up) begin
      freq_reg <= f_down;
    end else if (wr_freq && f_wr >= refchan_pkg::FREQ_MIN && int_fits(f_wr, harm_reg)) begin
      freq_reg <= f_wr;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) ampl_reg <= refchan_pkg::AMPL_RST;
    else if (kn_ampl && knob_up && !knob_down && ampl_reg < refchan_pkg::AMPL_MAX) ampl_reg <= ampl_reg + 12'h001;
    else if (kn_ampl && knob_down && !knob_up && ampl_reg > refchan_pkg::AMPL_MIN) ampl_reg <= ampl_reg - 12'h001;
    else if (wr_ampl && bus.wdata[11:0] >= refchan_pkg::AMPL_MIN && bus.wdata[11:0] <= refchan_pkg::AMPL_MAX)
      ampl_reg <= bus.wdata[11:0];
  end

  // a harmonic raise is allowed only while N times the reference stays within limit
  function automatic logic harm_ok(input logic [14:0] n);
    if (n == 15'd0 || n > refchan_pkg::HARM_MAX) return 1'b0;
    // the oscillator limit is kept in external mode too, so a later switch to
    // internal never leaves the setting above 102 kHz over N
    if (!int_fits(freq_reg, n)) return 1'b0;
    return internal_reg || !(locked && ext_too_fast(period_reg, n));
  endfunction : harm_ok

  logic harm_knob_up, harm_refused, ext_fold;
  assign harm_knob_up = kn_harm && knob_up && !knob_down;
  assign ext_fold = !internal_reg && locked && harm_reg > 15'd1 && ext_too_fast(period_reg, harm_reg);
  assign harm_refused = !ext_fold && ((harm_knob_up && !harm_ok(harm_reg + 15'd1)) ||
    (!(kn_harm && (knob_up || knob_down)) && wr_harm && !harm_ok(bus.wdata[14:0])));

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) harm_reg <= refchan_pkg::HARM_RST;
    else if (ext_fold) harm_reg <= 15'd1;
    else if (harm_knob_up) begin
      if (harm_ok(harm_reg + 15'd1)) harm_reg <= harm_reg + 15'd1;
    end else if (kn_harm && knob_down && !knob_up) begin
      if (harm_reg > 15'd1) harm_reg <= harm_reg - 15'd1;
    end else if (wr_harm && harm_ok(bus.wdata[14:0])) harm_reg <= bus.wdata[14:0];
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) overrange_reg <= 1'b0;
    else if (harm_refused) overrange_reg <= 1'b1;
    else if (wr_status && bus.wdata[refchan_pkg::ST_OVERRANGE_BIT]) overrange_reg <= 1'b0;
  end

  // square output: internal from a modulo accumulator, external restarts at each edge
  logic [41:0] nco_sum;
  assign nco_sum = nco_reg + 42'(freq_reg);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) nco_reg <= '0;
    else if (!internal_reg) nco_reg <= '0;
    else nco_reg <= (nco_sum >= refchan_pkg::NCO_MOD) ? nco_sum - refchan_pkg::NCO_MOD : nco_sum;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) ttl_sync_out <= 1'b0;
    else if (internal_reg) ttl_sync_out <= nco_reg < (refchan_pkg::NCO_MOD >> 1);
    else ttl_sync_out <= locked && (count_reg < (period_reg >> 1));
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b0;
    end else if (blink_cnt_reg == BLINK) begin
      blink_cnt_reg <= '0;
      blink_reg <= !blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'd1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      psd_ctrl <= '{phase: refchan_pkg::PHASE_RST, harmonic: refchan_pkg::HARM_RST};
      sine_ampl <= refchan_pkg::AMPL_RST;
      harm_led <= 1'b0;
      internal_led <= 1'b0;
      unlock_led <= 1'b0;
      harmonic_overrange_message <= 1'b0;
      phase_bad_message <= 1'b0;
    end else begin
      // phase reaches only the detector's sine; the sine output keeps zero phase
      psd_ctrl <= '{phase: phase_reg, harmonic: harm_reg};
      sine_ampl <= ampl_reg;
      harm_led <= harm_reg > 15'd1 && blink_reg;
      internal_led <= internal_reg;
      unlock_led <= !internal_reg && !locked;
      harmonic_overrange_message <= overrange_reg;
      phase_bad_message <= phase_bad_reg;
    end
  end

  // the frequency register reads the set frequency in both modes; the measured period reads from its own two registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) rdata <= '0;
    else if (bus.rd) begin
      case (bus.addr)
        refchan_pkg::OFS_CTRL: rdata <= 32'({trig_reg, internal_reg});
        refchan_pkg::OFS_PHASE: rdata <= 32'(signed'(phase_reg));
        refchan_pkg::OFS_FREQ: rdata <= 32'(freq_reg);
        refchan_pkg::OFS_AMPL: rdata <= 32'(ampl_reg);
        refchan_pkg::OFS_HARM: rdata <= 32'(harm_reg);
        refchan_pkg::OFS_STATUS: rdata <= 32'({locked, phase_bad_reg, overrange_reg, !internal_reg && !locked});
        refchan_pkg::OFS_PERIOD_LO: rdata <= period_reg[31:0];
        refchan_pkg::OFS_PERIOD_HI: rdata <= 32'(period_reg[37:32]);
        default: rdata <= '0;
      endcase
    end else rdata <= '0;
  end

  sequence s_both_keys;
    key_plus90 && key_minus90;
  endsequence
  sequence s_bad_zero;
    zero_cmd && !meas_phase_stable;
  endsequence

  property p_both_zero;
    @(posedge clock) disable iff (!arst_n) s_both_keys |=> phase_reg == 16'sd0 ##1 psd_ctrl.phase == 16'sd0;
  endproperty
  a_both_zero: assert property (p_both_zero) else $error("both keys did not zero phase");

  property p_plus90;
    @(posedge clock) disable iff (!arst_n)
      key_plus90 && !key_minus90 |=> phase_reg == wrap_phase(17'($past(phase_reg)) + 17'sd9000);
  endproperty
  a_plus90: assert property (p_plus90) else $error("plus 90 result wrong");

  property p_phase_range;
    @(posedge clock) disable iff (!arst_n) phase_reg <= 16'sd18000 && phase_reg >= -16'sd18000;
  endproperty
  a_phase_range: assert property (p_phase_range) else $error("phase out of range");

  property p_bad_zero;
    @(posedge clock) disable iff (!arst_n) s_bad_zero |=> $stable(phase_reg) ##1 phase_bad_message;
  endproperty
  a_bad_zero: assert property (p_bad_zero) else $error("unstable zeroing not aborted");

  property p_harm_led;
    @(posedge clock) disable iff (!arst_n) harm_reg == 15'd1 |=> !harm_led;
  endproperty
  a_harm_led: assert property (p_harm_led) else $error("harmonic led lit at N of one");

  property p_ext_fold;
    @(posedge clock) disable iff (!arst_n) ext_fold |=> harm_reg == 15'd1 ##1 psd_ctrl.harmonic == 15'd1;
  endproperty
  a_ext_fold: assert property (p_ext_fold) else $error("harmonic not reset");

  property p_freq_limit;
    @(posedge clock) disable iff (!arst_n)
      freq_reg >= refchan_pkg::FREQ_MIN && (!internal_reg || int_fits(freq_reg, harm_reg));
  endproperty
  a_freq_limit: assert property (p_freq_limit) else $error("frequency limit broken");

  property p_ampl_range;
    @(posedge clock) disable iff (!arst_n) sine_ampl >= 12'h002 && sine_ampl <= 12'h9C4;
  endproperty
  a_ampl_range: assert property (p_ampl_range) else $error("amplitude out of range");

  property p_internal_no_unlock;
    @(posedge clock) disable iff (!arst_n) internal_reg [*2] |=> !unlock_led;
  endproperty
  a_internal_no_unlock: assert property (p_internal_no_unlock) else $error("unlock in internal mode");

  property p_ext_knob;
    @(posedge clock) disable iff (!arst_n) !internal_reg && kn_freq && !wr_freq |=> $stable(freq_reg);
  endproperty
  a_ext_knob: assert property (p_ext_knob) else $error("knob moved frequency in external mode");

  property p_refuse;
    @(posedge clock) disable iff (!arst_n) harm_refused |=> $stable(harm_reg) ##1 harmonic_overrange_message;
  endproperty
  a_refuse: assert property (p_refuse) else $error("overrange not refused");
endmodule : reference_channel_control
`default_nettype wire

/* File: design/refchan_pkg.sv */
// constants and carrier types for the reference channel control block
// assumes a single 200 MHz clock domain
package refchan_pkg;
  localparam longint CLK_HZ = 200_000_000;
  localparam longint FMAX_HZ = 102_000;
  // frequency settings are held in units of 0.1 mHz
  localparam longint FREQ_UNITS_PER_HZ = 10_000;
  localparam logic [29:0] FREQ_MIN = 30'(10);
  localparam logic [29:0] FREQ_MAX = 30'(FMAX_HZ * FREQ_UNITS_PER_HZ);
  localparam logic [29:0] FREQ_RST = 30'(1_000 * FREQ_UNITS_PER_HZ);
  // shortest legal reference period, rounded up to whole cycles
  localparam logic [37:0] MIN_PERIOD = 38'((CLK_HZ + FMAX_HZ - 1) / FMAX_HZ);
  // slowest lockable reference is 0.001 Hz, a 1000 s period
  localparam longint LOCK_TIMEOUT_S = 1_000;
  localparam longint LOCK_TIMEOUT_CYCLES = CLK_HZ * LOCK_TIMEOUT_S;
  localparam longint BLINK_MS = 250;
  localparam longint BLINK_CYCLES = CLK_HZ / 1_000 * BLINK_MS;
  localparam logic [41:0] NCO_MOD = 42'(CLK_HZ * FREQ_UNITS_PER_HZ);
  // phase in units of 0.01 degree
  localparam logic signed [16:0] PHASE_LIMIT = 17'sd18000;
  localparam logic signed [16:0] PHASE_QUARTER = 17'sd9000;
  localparam logic signed [16:0] PHASE_FULL = 17'sd36000;
  localparam logic signed [15:0] PHASE_RST = 16'sh0000;
  // amplitude in units of 2 mV: 4 mVrms .. 5 Vrms
  localparam logic [11:0] AMPL_MIN = 12'h002;
  localparam logic [11:0] AMPL_MAX = 12'h9C4;
  localparam logic [11:0] AMPL_RST = 12'h1F4;
  localparam logic [14:0] HARM_MAX = 15'h4E1F;
  localparam logic [14:0] HARM_RST = 15'h0001;
  // register offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_PHASE = 5'h04;
  localparam logic [4:0] OFS_FREQ = 5'h08;
  localparam logic [4:0] OFS_AMPL = 5'h0C;
  localparam logic [4:0] OFS_HARM = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_PERIOD_LO = 5'h18;
  localparam logic [4:0] OFS_PERIOD_HI = 5'h1C;
  // field positions
  localparam int CTRL_INTERNAL_BIT = 0;
  localparam int CTRL_TRIG_LSB = 1;
  localparam int ST_UNLOCK_BIT = 0;
  localparam int ST_OVERRANGE_BIT = 1;
  localparam int ST_PHASE_BAD_BIT = 2;
  localparam int ST_LOCKED_BIT = 3;

  typedef enum logic [1:0] {TRIG_RISING, TRIG_FALLING, TRIG_SINE} trig_mode_type;
  typedef enum logic [1:0] {VIEW_PHASE, VIEW_FREQ, VIEW_AMPL, VIEW_HARM} panel_view_type;
  typedef struct packed {
    logic [4:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;
  typedef struct packed {
    logic signed [15:0] phase;
    logic [14:0] harmonic;
  } psd_ctrl_type;
endpackage : refchan_pkg

/* File: tb/ref_source.sv */
// external reference source for the reference channel bench
// assumes the bench enables it only while an external reference is wanted
`timescale 1ns/10ps
`default_nettype none
module ref_source #(
  parameter int HALF_NS = 10000
) (
  input wire logic enable,
  output logic ttl,
  output logic sine_cmp
);
  // logic-level square wave drives both pins; the comparator sees the same zero crossings
  assign sine_cmp = ttl;
  // switched off, the source rests low rather than holding its last level
  initial begin
    ttl = 1'b0;
    forever begin
      if (enable) begin
        #(HALF_NS) ttl = ~ttl;
      end else begin
        ttl = 1'b0;
        #10;
      end
    end
  end
endmodule : ref_source
`default_nettype wire

/* File: tb/reference_channel_control_bench.sv */
// self-checking bench for reference_channel_control
// assumes refchan_pkg is compiled first and ref_source drives both reference pins
`timescale 1ns/10ps
`default_nettype none
module reference_channel_control_bench;
  logic clock, arst_n, ena, ttl_pin, cmp_pin, meas_phase_stable;
  logic ttl_sync_out, harm_led, internal_led, unlock_led, over_msg, bad_msg;
  logic [6:0] keys;
  logic [31:0] rdata, v;
  logic [11:0] sine_ampl;
  logic signed [15:0] meas_phase;
  refchan_pkg::bus_req_type bus;
  refchan_pkg::panel_view_type view;
  refchan_pkg::psd_ctrl_type psd_ctrl;
  int fail_count = 0;
  int num_checks = 0;
  reference_channel_control #(.LOCK_TIMEOUT(5000), .BLINK_PERIOD(8)) reference_channel_control_inst (
    .clock(clock), .arst_n(arst_n), .bus(bus), .rdata(rdata), .key_plus90(keys[6]),
    .key_minus90(keys[5]), .key_phase_zero(keys[4]), .key_source(keys[3]), .key_trig(keys[2]),
    .knob_up(keys[1]), .knob_down(keys[0]), .view(view), .meas_phase(meas_phase),
    .meas_phase_stable(meas_phase_stable), .ref_ttl_pin(ttl_pin), .ref_sine_cmp_pin(cmp_pin),
    .psd_ctrl(psd_ctrl), .sine_ampl(sine_ampl), .ttl_sync_out(ttl_sync_out), .harm_led(harm_led),
    .internal_led(internal_led), .unlock_led(unlock_led), .harmonic_overrange_message(over_msg),
    .phase_bad_message(bad_msg));
  ref_source ref_source_inst (.enable(ena), .ttl(ttl_pin), .sine_cmp(cmp_pin));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rc(input string n, input logic [4:0] a, input logic [31:0] exp);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 v = rdata;
    chk(n, exp, v);
  endtask : rc
  // one-cycle key or knob pulse, then wait until the outputs follow
  task automatic press(input logic [6:0] k);
    @(posedge clock);
    keys <= k;
    @(posedge clock);
    keys <= 7'h00;
    repeat (2) @(posedge clock);
    #1;
  endtask : press
  task automatic ph(input int e);
    chk("phase", {16'h0000, 16'(e)}, {16'h0000, psd_ctrl.phase});
  endtask : ph
  task automatic wait_unlock(input logic lvl);
    for (int n = 0; n < 12000 && unlock_led !== lvl; n++) begin
      @(posedge clock);
      #1;
    end
    chk("unlock_led", {31'h0, lvl}, {31'h0, unlock_led});
  endtask : wait_unlock
  task automatic t_reset();
    rc("ampl", refchan_pkg::OFS_AMPL, 32'h0000_01F4);
    rc("harm", refchan_pkg::OFS_HARM, 32'h0000_0001);
    rc("freq", refchan_pkg::OFS_FREQ, 32'(refchan_pkg::FREQ_RST));
    chk("internal_led", 32'h0, {31'h0, internal_led});
    chk("unlock_led", 32'h1, {31'h0, unlock_led});
  endtask : t_reset
  task automatic t_quarter();
    press(7'h40); ph(9000);
    press(7'h40); ph(18000);
    press(7'h40); ph(-9000);
    press(7'h20); ph(-18000);
    press(7'h20); ph(9000);
    press(7'h60); ph(0);
  endtask : t_quarter
  task automatic t_zero();
    wr(refchan_pkg::OFS_PHASE, 32'h0000_0064);
    meas_phase <= 16'sh012C;
    press(7'h10); ph(-200);
    meas_phase <= 16'sh45EC;
    press(7'h10); ph(17900);
    meas_phase_stable <= 1'b0;
    press(7'h10); ph(17900);
    chk("phase_bad", 32'h1, {31'h0, bad_msg});
  endtask : t_zero
  task automatic t_ampl();
    wr(refchan_pkg::OFS_AMPL, 32'h0000_0001);
    rc("ampl low", refchan_pkg::OFS_AMPL, 32'h0000_01F4);
    wr(refchan_pkg::OFS_AMPL, 32'h0000_09C4);
    rc("ampl max", refchan_pkg::OFS_AMPL, 32'h0000_09C4);
    wr(refchan_pkg::OFS_AMPL, 32'h0000_09C5);
    rc("ampl high", refchan_pkg::OFS_AMPL, 32'h0000_09C4);
    chk("sine_ampl", 32'h0000_09C4, {20'h0, sine_ampl});
    view <= refchan_pkg::VIEW_AMPL;
    press(7'h02);
    rc("ampl knob max", refchan_pkg::OFS_AMPL, 32'h0000_09C4);
    press(7'h01);
    rc("ampl knob step", refchan_pkg::OFS_AMPL, 32'h0000_09C3);
    view <= refchan_pkg::VIEW_PHASE;
  endtask : t_ampl
  task automatic t_harm();
    int t;
    logic prev;
    wr(refchan_pkg::OFS_HARM, 32'h0000_4E1F);
    rc("harm over", refchan_pkg::OFS_HARM, 32'h0000_0001);
    chk("overrange", 32'h1, {31'h0, over_msg});
    wr(refchan_pkg::OFS_HARM, 32'h0000_0066);
    rc("harm edge", refchan_pkg::OFS_HARM, 32'h0000_0066);
    chk("psd harm", 32'h0000_0066, {17'h0, psd_ctrl.harmonic});
    t = 0;
    prev = harm_led;
    repeat (40) begin
      @(posedge clock);
      #1;
      t += (harm_led !== prev) ? 1 : 0;
      prev = harm_led;
    end
    chk("harm_led blinks", 32'h1, {31'h0, t >= 2});
    view <= refchan_pkg::VIEW_HARM;
    press(7'h02);
    rc("harm knob", refchan_pkg::OFS_HARM, 32'h0000_0066);
    wr(refchan_pkg::OFS_FREQ, 32'(refchan_pkg::FREQ_RST) + 32'h1);
    rc("freq limit", refchan_pkg::OFS_FREQ, 32'(refchan_pkg::FREQ_RST));
  endtask : t_harm
  task automatic t_source();
    logic [31:0] f;
    press(7'h08);
    chk("internal_led", 32'h1, {31'h0, internal_led});
    view <= refchan_pkg::VIEW_FREQ;
    press(7'h01);
    // one knob step down from 1 kHz is 0.1 Hz at four and a half digits
    f = 32'(refchan_pkg::FREQ_RST) - 32'h0000_03E8;
    rc("freq", refchan_pkg::OFS_FREQ, f);
    chk("knob internal", 32'h1, {31'h0, v < 32'(refchan_pkg::FREQ_RST)});
    press(7'h08);
    press(7'h01);
    rc("knob external", refchan_pkg::OFS_FREQ, f);
  endtask : t_source
  task automatic t_lock();
    int n;
    for (int k = 0; k < 3; k++) begin
      ena <= 1'b0;
      wait_unlock(1'b1);
      wr(refchan_pkg::OFS_CTRL, 32'(k << 1));
      ena <= 1'b1;
      wait_unlock(1'b0);
    end
    // locked to a 4000-cycle reference: the square output is high for half of it
    n = 0;
    repeat (4000) begin
      @(posedge clock);
      #1;
      n += ttl_sync_out ? 1 : 0;
    end
    chk("sync duty", 32'h0000_07D0, 32'(n));
    rc("harm folded", refchan_pkg::OFS_HARM, 32'h0000_0001);
    press(7'h04);
    rc("trig cycle", refchan_pkg::OFS_CTRL, 32'h0000_0000);
  endtask : t_lock
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #400_000;
    fail_count++;
    conclude();
  end
  initial begin
    arst_n = 1'b0;
    bus = '0;
    keys = 7'h00;
    view = refchan_pkg::VIEW_PHASE;
    meas_phase = 16'sh0000;
    meas_phase_stable = 1'b1;
    ena = 1'b0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    t_reset();
    t_quarter();
    t_zero();
    t_ampl();
    t_harm();
    t_source();
    t_lock();
    conclude();
  end
endmodule : reference_channel_control_bench
`default_nettype wire
